// >>> chf_pkg.sv
package chf_pkg;

    localparam int FRAME_SAMPLES = 160;
    localparam int SAMPLE_BITS = 13;
    localparam int WORD_BITS = 16;
    localparam logic [15:0] ENC_HOME_WORD = 16'h0008;
    localparam int NUM_MODES = 8;
    localparam int PARAM_BITS = 244;
    localparam int EARLY_BITS = 81;
    localparam int FIFO_DEPTH = 32;

    typedef logic [2:0] chf_mode_t;

    typedef struct packed {
        logic [15:0] word;
        logic        first;
    } chf_pcm_t;

    typedef struct packed {
        logic [PARAM_BITS-1:0] bits;
        chf_mode_t             mode;
    } chf_par_t;

endpackage

// >>> chf_fifo.sv
`timescale 1ns/1ps
module chf_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // chf_fifo

// >>> chf_homing.sv
// Functional notes
// R01: home input is 160 equal 13-bit samples
// R02: left-justified 16-bit words compare to 0008 hex
// R03: one encoder pattern for all modes
// R04: eight decoder patterns, pick current mode
// R05: pattern must match encoder frame boundaries
// R06: homing frame first processed and emitted normally
// R07: encoder sub-modules reset after that frame
// R08: N encoder homes give N-1 decoder homes
// R09: decoder homes only on current mode pattern
// R10: from home state, output encoder pattern
// R11: decoder sub-modules reset after that frame
// R12: home state allows early partial compare
// R13: test source first frame must differ early
// R14: N decoder homes give N-1 encoder homes
// R15: controller sets mode at reset time
// R16: any reset loads every initial state
// R17: flag shows frame began in home state
`timescale 1ns/1ps
module chf_homing
    import chf_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_SAMPLES,
    parameter int DEPTH = FIFO_DEPTH,
    parameter logic [NUM_MODES*PARAM_BITS-1:0] DEC_HOME_TABLE = '0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // codec mode, sampled on the first clock after reset release
    input wire chf_mode_t mode_in,
    // pcm samples into the encoder
    input wire logic pcm_valid,
    output logic pcm_ready,
    input wire chf_pcm_t pcm_in,
    // samples towards encoder core
    output logic enc_valid,
    input wire logic enc_ready,
    output chf_pcm_t enc_out,
    // encoder core frame done
    input wire logic enc_frame_done,
    output logic enc_home_reset,
    output logic enc_in_home,
    output logic enc_home_seen,
    // decoder parameter frames
    input wire logic par_valid,
    input wire chf_par_t par_in,
    input wire logic dec_frame_done,
    output logic dec_home_reset,
    output logic dec_in_home,
    output logic dec_match,
    output logic dec_early_match,
    output logic dec_substitute,
    output logic [15:0] dec_sub_word,
    // current mode
    output chf_mode_t mode
);

    ////////////////////////////////////////////////////////////////////////////
    // mode register
    logic rst_seen;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_seen <= 1'b1;
        end else begin
            rst_seen <= 1'b0;
        end
    end

    // caught just after release so the async-free reset never loads a port
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode <= '0;
        end else if (rst_seen) begin
            mode <= mode_in; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input buffer; the encoder core can stall it
    logic fifo_in_valid;
    logic fifo_in_ready;
    chf_pcm_t fifo_out;

    assign fifo_in_valid = pcm_valid;
    assign pcm_ready = fifo_in_ready;

    chf_fifo #(
        .WIDTH($bits(chf_pcm_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(pcm_in),
        .out_valid(enc_valid),
        .out_ready(enc_ready),
        .out_data(fifo_out)
    );
    assign enc_out = fifo_out;

    ////////////////////////////////////////////////////////////////////////////
    // encoder homing detection
    localparam int CW = $clog2(FRAME_LEN + 1);
    logic [CW-1:0] samp_cnt;
    logic all_home;
    logic enc_take;
    logic word_home;
    logic home_pending;

    assign enc_take = enc_valid && enc_ready;
    // 13-bit lsb set and left-justified in 16 bits gives one fixed word
    assign word_home = (enc_out.word == ENC_HOME_WORD); // R01 R02 R03

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            samp_cnt <= '0;
            // cleared so an unmarked first frame after reset can never home
            all_home <= 1'b0; // R05 R16
            enc_home_seen <= 1'b0;
        end else begin
            enc_home_seen <= 1'b0;
            if (enc_take) begin
                // first marks the core's own segmentation start
                if (enc_out.first || samp_cnt == CW'(FRAME_LEN)) begin // R05
                    samp_cnt <= CW'(1);
                    all_home <= word_home && enc_out.first;
                end else begin
                    samp_cnt <= samp_cnt + 1'b1;
                    all_home <= all_home && word_home;
                end
                if (samp_cnt == CW'(FRAME_LEN - 1) && !enc_out.first) begin
                    enc_home_seen <= all_home && word_home; // R01
                end
            end
        end
    end

    // core finishes the frame normally before the home reset fires
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            home_pending <= 1'b0;
        end else if (enc_home_seen) begin
            home_pending <= 1'b1; // R06
        end else if (enc_frame_done) begin
            home_pending <= 1'b0;
        end
    end

    assign enc_home_reset = enc_frame_done && home_pending; // R07 R08

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            enc_in_home <= 1'b1; // R16
        end else if (enc_home_reset) begin
            enc_in_home <= 1'b1; // R17
        end else if (enc_frame_done) begin
            enc_in_home <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoder homing detection
    logic [PARAM_BITS-1:0] sel_pat;
    logic full_eq;
    logic early_eq;
    logic dec_pending;

    assign sel_pat = DEC_HOME_TABLE[mode*PARAM_BITS +: PARAM_BITS]; // R04
    assign full_eq = (par_in.bits == sel_pat) && (par_in.mode == mode); // R09
    // leading bits hold lp and first-subframe fields; test data differs there
    assign early_eq = (par_in.bits[PARAM_BITS-1 -: EARLY_BITS]
                       == sel_pat[PARAM_BITS-1 -: EARLY_BITS])
                      && (par_in.mode == mode); // R12 R13

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dec_match <= 1'b0;
            dec_early_match <= 1'b0;
        end else begin
            dec_match <= par_valid && full_eq; // R09
            dec_early_match <= par_valid && early_eq && dec_in_home; // R12
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dec_pending <= 1'b0;
            dec_substitute <= 1'b0;
        end else if (par_valid) begin
            dec_pending <= full_eq;
            dec_substitute <= full_eq && dec_in_home; // R10 R14
        end else if (dec_frame_done) begin
            dec_pending <= 1'b0;
            dec_substitute <= 1'b0;
        end
    end

    assign dec_home_reset = dec_frame_done && dec_pending; // R11
    assign dec_sub_word = ENC_HOME_WORD; // R03

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dec_in_home <= 1'b1; // R16
        end else if (dec_home_reset) begin
            dec_in_home <= 1'b1; // R17
        end else if (dec_frame_done) begin
            dec_in_home <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_dec_home_frame;
        par_valid && full_eq && dec_in_home;
    endsequence

    property p_enc_reset_cause;
        @(posedge core_clk) disable iff (sys_rst)
        enc_home_reset |-> home_pending && enc_frame_done;
    endproperty
    a_enc_reset_cause: assert property (p_enc_reset_cause) // R07
        else $error("encoder home reset without detected frame");

    property p_enc_home_after;
        @(posedge core_clk) disable iff (sys_rst)
        enc_home_reset |=> enc_in_home;
    endproperty
    a_enc_home_after: assert property (p_enc_home_after) // R17
        else $error("encoder flag not set after homing");

    property p_enc_plain_clear;
        @(posedge core_clk) disable iff (sys_rst)
        enc_frame_done && !home_pending |=> !enc_in_home;
    endproperty
    a_enc_plain_clear: assert property (p_enc_plain_clear) // R17
        else $error("encoder flag kept after plain frame");

    property p_dec_subst;
        @(posedge core_clk) disable iff (sys_rst)
        s_dec_home_frame |=> dec_substitute && dec_match;
    endproperty
    a_dec_subst: assert property (p_dec_subst) // R10
        else $error("decoder did not substitute home pattern");

    property p_dec_no_other_mode;
        @(posedge core_clk) disable iff (sys_rst)
        par_valid && par_in.mode != mode |=> !dec_match && !dec_substitute;
    endproperty
    a_dec_no_other_mode: assert property (p_dec_no_other_mode) // R09
        else $error("decoder homed on foreign mode");

    property p_dec_reset;
        @(posedge core_clk) disable iff (sys_rst)
        dec_home_reset |=> dec_in_home;
    endproperty
    a_dec_reset: assert property (p_dec_reset) // R11
        else $error("decoder flag not set after homing");

    property p_dec_word;
        @(posedge core_clk) disable iff (sys_rst)
        dec_substitute |-> dec_sub_word == 16'h0008;
    endproperty
    a_dec_word: assert property (p_dec_word) // R02
        else $error("substitute word wrong");

    property p_early_home;
        @(posedge core_clk) disable iff (sys_rst)
        dec_early_match |-> $past(dec_in_home);
    endproperty
    a_early_home: assert property (p_early_home) // R12
        else $error("early match outside home state");

    property p_mode_load;
        @(posedge core_clk) disable iff (sys_rst)
        rst_seen && !sys_rst |=> mode == $past(mode_in);
    endproperty
    a_mode_load: assert property (p_mode_load) // R15
        else $error("mode not captured after reset");

    sequence s_enc_detect;
        enc_home_seen && !enc_frame_done;
    endsequence

    sequence s_enc_done;
        enc_frame_done;
    endsequence

    property p_enc_detect_reset;
        @(posedge core_clk) disable iff (sys_rst)
        s_enc_detect ##1 s_enc_done |-> enc_home_reset;
    endproperty
    a_enc_detect_reset: assert property (p_enc_detect_reset) // R07
        else $error("encoder home reset missed after detected frame");

    property p_enc_seen_aligned;
        @(posedge core_clk) disable iff (sys_rst)
        enc_home_seen |-> samp_cnt == CW'(FRAME_LEN);
    endproperty
    a_enc_seen_aligned: assert property (p_enc_seen_aligned) // R05
        else $error("encoder home seen off frame boundary");

    property p_enc_seen_word;
        @(posedge core_clk) disable iff (sys_rst)
        enc_home_seen |-> $past(enc_take && word_home);
    endproperty
    a_enc_seen_word: assert property (p_enc_seen_word) // R01
        else $error("encoder home seen without home sample");

    property p_enc_word_form;
        @(posedge core_clk) disable iff (sys_rst)
        word_home |-> enc_out.word == {13'h0001, 3'h0};
    endproperty
    a_enc_word_form: assert property (p_enc_word_form) // R02
        else $error("home word is not a left-justified lsb sample");

    property p_enc_first_no_seen;
        @(posedge core_clk) disable iff (sys_rst)
        enc_take && enc_out.first |=> !enc_home_seen;
    endproperty
    a_enc_first_no_seen: assert property (p_enc_first_no_seen) // R05
        else $error("encoder home seen on a frame start");

    property p_dec_plain_clear;
        @(posedge core_clk) disable iff (sys_rst)
        dec_frame_done && !dec_pending |=> !dec_in_home;
    endproperty
    a_dec_plain_clear: assert property (p_dec_plain_clear) // R17
        else $error("decoder flag kept after plain frame");

    property p_dec_no_sub_away;
        @(posedge core_clk) disable iff (sys_rst)
        par_valid && !dec_in_home |=> !dec_substitute;
    endproperty
    a_dec_no_sub_away: assert property (p_dec_no_sub_away) // R10
        else $error("decoder substituted outside home state");

    property p_dec_sub_hold;
        @(posedge core_clk) disable iff (sys_rst)
        dec_substitute && !par_valid && !dec_frame_done |=> dec_substitute;
    endproperty
    a_dec_sub_hold: assert property (p_dec_sub_hold) // R10
        else $error("decoder substitution dropped mid frame");

    property p_dec_early_mode;
        @(posedge core_clk) disable iff (sys_rst)
        par_valid && par_in.mode != mode |=> !dec_early_match;
    endproperty
    a_dec_early_mode: assert property (p_dec_early_mode) // R09
        else $error("early match on foreign mode");

endmodule // chf_homing

// >>> chf_enc_model.sv
`timescale 1ns/1ps
module chf_enc_model
    import chf_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_SAMPLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // sample stream from the fifo
    input wire logic enc_valid,
    output logic enc_ready,
    input wire chf_pcm_t enc_out,
    // test control and frame completion
    input wire logic stall,
    output logic enc_frame_done
);
    int seed = 81968;
    int cnt;
    logic fin;
    ////////////////////////////////////////////////////////////
    // random back-pressure so the fifo sees both prompt and slow drains
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            enc_ready <= 1'b0;
            enc_frame_done <= 1'b0;
            fin <= 1'b0;
            cnt <= 0;
        end else begin
            enc_ready <= !stall && (($random(seed) & 1) == 1);
            fin <= 1'b0;
            // the core needs a cycle after the last sample before it reports
            enc_frame_done <= fin;
            if (enc_valid && enc_ready) begin
                if (cnt == FRAME_LEN - 1) begin
                    cnt <= 0;
                    fin <= 1'b1;
                end else begin
                    cnt <= cnt + 1;
                end
            end
        end
    end
endmodule // chf_enc_model

// >>> codec_homing_frame_control_tb_top.sv
`timescale 1ns/1ps
module codec_homing_frame_control_tb_top
    import chf_pkg::*;
;
    localparam int FL = 4;
    function automatic logic [243:0] pat(input int m);
        pat = {61{4'(m + 1)}};
    endfunction
    function automatic logic [NUM_MODES*PARAM_BITS-1:0] mk_tbl();
        for (int m = 0; m < NUM_MODES; m++) begin
            mk_tbl[m*PARAM_BITS +: PARAM_BITS] = pat(m);
        end
    endfunction
    localparam logic [NUM_MODES*PARAM_BITS-1:0] TBL = mk_tbl();
    logic core_clk = 1'b0, sys_rst = 1'b1, pcm_valid = 1'b0, par_valid = 1'b0;
    logic dec_frame_done = 1'b0, stall = 1'b0, enc_valid, enc_ready, enc_frame_done;
    logic pcm_ready, enc_home_reset, enc_in_home, enc_home_seen, dec_home_reset, dec_in_home;
    logic dec_match, dec_early_match, dec_substitute;
    logic [15:0] dec_sub_word;
    logic [255:0] r;
    chf_pcm_t pcm_in = '0, enc_out;
    chf_par_t par_in = '0;
    chf_mode_t mode_in, mode, m, om;
    int seed = 81968, n_errors = 0, cmp_count = 0, n_seen = 0, n_hrst = 0, s0, r0, acc, rd;
    logic [15:0] q [40];
    always #5 core_clk = ~core_clk;
    chf_homing #(.FRAME_LEN(FL), .DEPTH(FIFO_DEPTH), .DEC_HOME_TABLE(TBL)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .mode_in(mode_in), .pcm_valid(pcm_valid),
        .pcm_ready(pcm_ready), .pcm_in(pcm_in), .enc_valid(enc_valid), .enc_ready(enc_ready),
        .enc_out(enc_out), .enc_frame_done(enc_frame_done), .enc_home_reset(enc_home_reset),
        .enc_in_home(enc_in_home), .enc_home_seen(enc_home_seen), .par_valid(par_valid),
        .par_in(par_in), .dec_frame_done(dec_frame_done), .dec_home_reset(dec_home_reset),
        .dec_in_home(dec_in_home), .dec_match(dec_match), .dec_early_match(dec_early_match),
        .dec_substitute(dec_substitute), .dec_sub_word(dec_sub_word), .mode(mode));
    chf_enc_model #(.FRAME_LEN(FL)) u_core (.core_clk(core_clk), .sys_rst(sys_rst),
        .enc_valid(enc_valid), .enc_ready(enc_ready), .enc_out(enc_out), .stall(stall),
        .enc_frame_done(enc_frame_done));
    ////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (enc_home_seen === 1'b1) n_seen++;
        if (enc_home_reset === 1'b1) n_hrst++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one frame then frame done; md its mode; em/ee/es expect match, early, substitute
    task automatic dtx(input logic [243:0] b, input chf_mode_t md, input logic em,
                       input logic ee, input logic es);
        @(posedge core_clk);
        par_valid <= 1'b1;
        par_in <= {b, md};
        @(posedge core_clk);
        par_valid <= 1'b0;
        #1;
        check(dec_match, em);
        if (!em) check(dec_early_match, ee);
        check(dec_substitute, es);
        if (es) check(dec_sub_word, ENC_HOME_WORD);
        @(posedge core_clk);
        dec_frame_done <= 1'b1;
        #1;
        check(dec_home_reset, em);
        @(posedge core_clk);
        dec_frame_done <= 1'b0;
        #1;
        check(dec_in_home, em);
    endtask
    task automatic push(input logic [15:0] w, input logic f);
        pcm_valid <= 1'b1;
        pcm_in <= {w, f};
        @(negedge core_clk);
        for (int k = 0; k < 1000 && !pcm_ready; k++) @(negedge core_clk);
        if (pcm_ready !== 1'b1) n_errors++;
        @(posedge core_clk);
    endtask
    // frames of one word; al marks the first sample so the frame is aligned
    task automatic ptx(input logic [15:0] w, input logic al, input int n);
        @(posedge core_clk);
        s0 = n_seen;
        r0 = n_hrst;
        for (int j = 0; j < n * FL; j++) push(w, al && (j % FL == 0));
        pcm_valid <= 1'b0;
        for (int k = 0; k < 1000 && enc_valid !== 1'b0; k++) @(posedge core_clk);
        if (enc_valid !== 1'b0) n_errors++;
        repeat (8) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
    initial begin
        m = 3'($random(seed));
        om = m ^ 3'h1;
        mode_in = m;
        repeat (16) @(posedge core_clk);
        #1;
        check(pcm_ready, 1'b1);
        check(enc_valid, 1'b0);
        check({enc_in_home, dec_in_home}, 2'h3);
        check(mode, 3'h0);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check(mode, m);
        dtx(pat(om), m, 1'b0, 1'b0, 1'b0);
        dtx(pat(m), om, 1'b0, 1'b0, 1'b0);
        dtx(pat(m), m, 1'b1, 1'b0, 1'b0);
        dtx(pat(m), m, 1'b1, 1'b0, 1'b1);
        dtx(pat(m), m, 1'b1, 1'b0, 1'b1);
        dtx(pat(m) ^ 244'h1, m, 1'b0, 1'b1, 1'b0);
        r = {8{32'($random(seed))}};
        dtx(r[243:0], m, 1'b0, 1'b0, 1'b0);
        $display("test decoder done");
        ptx(16'h0008, 1'b1, 3);
        check(16'(n_seen - s0), 16'h0003);
        check(16'(n_hrst - r0), 16'h0003);
        check(enc_in_home, 1'b1);
        ptx(16'h0008, 1'b0, 1);
        check(16'(n_seen - s0), 16'h0000);
        check(enc_in_home, 1'b0);
        ptx(16'h0009, 1'b1, 1);
        check(16'(n_seen - s0), 16'h0000);
        check(16'(n_hrst - r0), 16'h0000);
        $display("test encoder done");
        stall <= 1'b1;
        repeat (3) @(posedge core_clk);
        acc = 0;
        for (int k = 0; k < 40; k++) begin
            pcm_valid <= 1'b1;
            q[k] = 16'($random(seed)) | 16'h8000;
            pcm_in <= {q[k], k % FL == 0};
            @(negedge core_clk);
            if (!pcm_ready) break;
            acc++;
            @(posedge core_clk);
        end
        @(posedge core_clk);
        pcm_valid <= 1'b0;
        check(16'(acc), 16'(FIFO_DEPTH));
        stall <= 1'b0;
        rd = 0;
        for (int k = 0; k < 1000 && enc_valid !== 1'b0; k++) begin
            @(negedge core_clk);
            if (enc_valid === 1'b1 && enc_ready === 1'b1) begin
                check(enc_out.word, q[rd]);
                rd++;
            end
        end
        @(posedge core_clk);
        #1;
        check(enc_valid, 1'b0);
        check(16'(rd), 16'(FIFO_DEPTH));
        $display("test fifo done");
        conclude();
    end
endmodule // codec_homing_frame_control_tb_top
